/* tap_bridge_pkg.sv */
// Shared constants, state codes and carrier types of the test port bridge
package tap_bridge_pkg;

  // Instruction and data path widths
  localparam int IR_W = 8;
  localparam int DR_W = 8;

  // User instruction range, inclusive on both ends
  localparam logic [7:0] USER_IR_LO = 8'h10;
  localparam logic [7:0] USER_IR_HI = 8'h7f;

  // Instruction after controller reset (bypass) and captured IR pattern
  localparam logic [7:0] IR_RESET_VAL   = 8'hff;
  localparam logic [7:0] IR_CAPTURE_VAL = 8'h01;

  // Host must hold TMS high this many test clocks to force a reset
  localparam int TMS_RESET_CYCLES = 5;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  // Sixteen controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET  = 16'h0001,
    ST_IDLE   = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PAU_DR = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PAU_IR = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;

  // One data word handed to the fabric with the instruction it ran under
  typedef struct packed {
    logic [IR_W-1:0] instr;
    logic [DR_W-1:0] data;
  } user_word_t;

  // Fabric-facing flags of the controller
  typedef struct packed {
    logic reset_n;
    logic capture;
    logic shift;
    logic update;
  } tap_flags_t;

endpackage

/* bit_sync.sv */
// Two-flop level synchroniser into the destination clock
`timescale 1ns/1ps
module bit_sync
  import tap_bridge_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_regs_t;

  sync_regs_t r_r;
  sync_regs_t r_nxt;

  // First stage feeds only the second
  always_comb begin
    r_nxt    = r_r;
    r_nxt.s1 = d;
    r_nxt.s2 = r_r.s1;
    if (rst) begin
      r_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    r_r <= r_nxt;
  end

  assign q = r_r.s2;

endmodule

/* skid_buffer.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module skid_buffer
  import tap_bridge_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  typedef struct packed {
    logic         out_v;
    logic [W-1:0] out_d;
    logic         spare_v;
    logic [W-1:0] spare_d;
  } buf_regs_t;

  buf_regs_t r_r;
  buf_regs_t r_nxt;
  logic      in_fire;

  // Accept only while the spare slot is free, so no word is lost
  always_comb begin
    r_nxt   = r_r;
    in_fire = in_valid && !r_r.spare_v;
    if (!r_r.out_v || out_ready) begin
      if (r_r.spare_v) begin
        r_nxt.out_v   = 1'b1;
        r_nxt.out_d   = r_r.spare_d;
        r_nxt.spare_v = 1'b0;
      end else if (in_fire) begin
        r_nxt.out_v = 1'b1;
        r_nxt.out_d = in_data;
      end else begin
        r_nxt.out_v = 1'b0;
      end
    end else if (in_fire) begin
      r_nxt.spare_v = 1'b1;
      r_nxt.spare_d = in_data;
    end
    if (rst) begin
      r_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    r_r <= r_nxt;
  end

  assign in_ready  = !r_r.spare_v;
  assign out_valid = r_r.out_v;
  assign out_data  = r_r.out_d;

  // A stalled output word holds still
  AST_BUF_HOLD: assert property (@(posedge clk) disable iff (rst)
    (out_valid && !out_ready) |=> (out_valid && $stable(out_data)))
    else $error("Stalled buffer output changed");

endmodule

/* user_test_port_tile.sv */
// Test port controller bridged to fabric logic, with a word stream to mclk
//
// Operation
// - The full 8-bit instruction register is shown on the instruction bus.
// - Instructions 16 to 127 belong to the user and route user data.
// - The user reset output is low while the controller is in reset.
// - Power-on reset puts the controller in reset, asserting user reset.
// - User reset stays asserted until a port access leaves reset.
// - The user serial input is the TDI pin wired straight through.
// - The user test clock is the TCK pin wired straight through.
// - User serial output reaches TDO only under a user instruction.
// - The shift flag is high exactly while in Shift-DR.
// - The capture flag is high exactly while in Capture-DR.
// - The update flag is high exactly while in Update-DR.
// - The instruction bus changes only on entry to Update-IR or to reset.
// - Power-up, test reset or TMS held high all lead to reset.
// - The state moves on rising TCK, steered by sampled TMS, except that low TRST forces reset at once.
`timescale 1ns/1ps
module user_test_port_tile
  import tap_bridge_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            tck,
  input  wire logic            trst_n,
  input  wire logic            tms,
  input  wire logic            tdi,
  output logic                 tdo,
  output logic                 tdo_oe_n,
  output logic [IR_W-1:0]      user_instruction_bus,
  output logic                 user_tap_reset_n,
  output logic                 user_serial_in,
  output logic                 user_test_clock,
  input  wire logic            user_serial_out,
  output logic                 data_shift_flag,
  output logic                 data_capture_flag,
  output logic                 data_update_flag,
  output logic                 word_valid,
  input  wire logic            word_ready,
  output user_word_t           word_data,
  output logic                 word_overrun
);

  //////////////////////////////////////////////////////////////////////////
  // Test clock domain state

  typedef struct packed {
    tap_state_t      state;
    logic [IR_W-1:0] ir_shift;
    logic [IR_W-1:0] ir;
    logic [DR_W-1:0] dr_shift;
    logic            bypass;
    tap_flags_t      flags;
    user_word_t      word;
    logic            word_tog;
  } tap_regs_t;

  typedef struct packed {
    logic tdo;
    logic oe_n;
  } tdo_regs_t;

  tap_regs_t  t_r;
  tap_regs_t  t_nxt;
  tdo_regs_t  o_r;
  tdo_regs_t  o_nxt;
  tap_state_t st_nxt;
  logic       por_tck;
  logic       ir_user;

  // Power-on reset brought over onto the test clock
  bit_sync #(
    .W (1)
  ) u_por_sync (
    .clk (tck),
    .rst (1'b0),
    .d   (rst),
    .q   (por_tck)
  );

  // Loaded instruction lies in the user range
  assign ir_user = (t_r.ir >= USER_IR_LO) && (t_r.ir <= USER_IR_HI);

  //////////////////////////////////////////////////////////////////////////
  // Controller transitions

  // Next state from the sampled TMS level
  always_comb begin
    st_nxt = ST_RESET;
    case (t_r.state)
      ST_RESET:  st_nxt = tms ? ST_RESET  : ST_IDLE;
      ST_IDLE:   st_nxt = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: st_nxt = tms ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: st_nxt = tms ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: st_nxt = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: st_nxt = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: st_nxt = tms ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: st_nxt = tms ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: st_nxt = tms ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: st_nxt = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: st_nxt = tms ? ST_SEL_DR : ST_IDLE;
      default:   st_nxt = ST_RESET;
    endcase
    if (por_tck) begin
      st_nxt = ST_RESET;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register actions on each rising test clock

  // Shift paths, instruction load, flags and word hand-off
  always_comb begin
    t_nxt       = t_r;
    t_nxt.state = st_nxt;
    case (t_r.state)
      ST_CAP_IR: t_nxt.ir_shift = IR_CAPTURE_VAL;
      ST_SH_IR:  t_nxt.ir_shift = {tdi, t_r.ir_shift[IR_W-1:1]};
      ST_CAP_DR: begin
        t_nxt.bypass   = 1'b0;
        t_nxt.dr_shift = '0;
      end
      ST_SH_DR: begin
        t_nxt.bypass   = tdi;
        t_nxt.dr_shift = {tdi, t_r.dr_shift[DR_W-1:1]};
      end
      default: t_nxt.bypass = t_r.bypass;
    endcase
    // Instruction moves to the fabric only on entry to Update-IR
    if (st_nxt == ST_UPD_IR && t_r.state != ST_UPD_IR) begin
      t_nxt.ir = t_r.ir_shift;
    end
    if (st_nxt == ST_RESET) begin
      t_nxt.ir = IR_RESET_VAL;
    end
    // A completed user data scan becomes one word for mclk
    if (st_nxt == ST_UPD_DR && t_r.state != ST_UPD_DR && ir_user) begin
      t_nxt.word.instr = t_r.ir;
      t_nxt.word.data  = t_r.dr_shift;
      t_nxt.word_tog   = !t_r.word_tog;
    end
    // Flags follow the state they will sit in
    t_nxt.flags.reset_n = (st_nxt != ST_RESET);
    t_nxt.flags.capture = (st_nxt == ST_CAP_DR);
    t_nxt.flags.shift   = (st_nxt == ST_SH_DR);
    t_nxt.flags.update  = (st_nxt == ST_UPD_DR);
    // Power-on clears the whole controller, hand-off toggle included
    if (por_tck) begin
      t_nxt.ir_shift = IR_CAPTURE_VAL;
      t_nxt.dr_shift = '0;
      t_nxt.bypass   = 1'b0;
      t_nxt.word     = '0;
      t_nxt.word_tog = 1'b0;
    end
  end

  // Test reset pin forces the controller to reset at once
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      t_r.state    <= ST_RESET;
      t_r.ir_shift <= IR_CAPTURE_VAL;
      t_r.ir       <= IR_RESET_VAL;
      t_r.dr_shift <= '0;
      t_r.bypass   <= 1'b0;
      t_r.flags    <= 4'h0;
      t_r.word     <= '0;
      t_r.word_tog <= 1'b0;
    end else begin
      t_r <= t_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Test data output, changed on the falling test clock

  // Instruction shift, user data or bypass onto TDO
  always_comb begin
    o_nxt      = o_r;
    o_nxt.oe_n = 1'b1;
    o_nxt.tdo  = 1'b0;
    if (t_r.state == ST_SH_IR) begin
      o_nxt.oe_n = 1'b0;
      o_nxt.tdo  = t_r.ir_shift[0];
    end else if (t_r.state == ST_SH_DR) begin
      o_nxt.oe_n = 1'b0;
      o_nxt.tdo  = ir_user ? user_serial_out : t_r.bypass;
    end
  end

  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      o_r <= 2'h1;
    end else begin
      o_r <= o_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fabric-facing test clock outputs

  assign user_instruction_bus = t_r.ir;
  assign user_tap_reset_n     = t_r.flags.reset_n;
  assign data_capture_flag    = t_r.flags.capture;
  assign data_shift_flag      = t_r.flags.shift;
  assign data_update_flag     = t_r.flags.update;
  assign user_serial_in       = tdi;
  assign user_test_clock      = tck;
  assign tdo                  = o_r.tdo;
  assign tdo_oe_n             = o_r.oe_n;

  //////////////////////////////////////////////////////////////////////////
  // Word stream into the mclk domain

  typedef struct packed {
    logic       seen;
    logic       pend_v;
    user_word_t pend;
    logic       overrun;
  } m_regs_t;

  m_regs_t    m_r;
  m_regs_t    m_nxt;
  logic       tog_m;
  logic       new_word;
  logic       buf_ready;

  // Toggle crossing; the word itself is stable long before it is read
  bit_sync #(
    .W (1)
  ) u_tog_sync (
    .clk (mclk),
    .rst (rst),
    .d   (t_r.word_tog),
    .q   (tog_m)
  );

  // Hold one word until the buffer takes it
  always_comb begin
    m_nxt    = m_r;
    new_word = tog_m ^ m_r.seen;
    m_nxt.seen = tog_m;
    if (buf_ready) begin
      m_nxt.pend_v = 1'b0;
    end
    if (new_word) begin
      if (m_r.pend_v && !buf_ready) begin
        m_nxt.overrun = 1'b1;
      end
      m_nxt.pend_v = 1'b1;
      m_nxt.pend   = t_r.word;
    end
    if (rst) begin
      m_nxt = '0;
    end
  end

  always_ff @(posedge mclk) begin
    m_r <= m_nxt;
  end

  // Receiver stall backs up into the pending word
  skid_buffer #(
    .W ($bits(user_word_t))
  ) u_word_buf (
    .clk       (mclk),
    .rst       (rst),
    .in_valid  (m_r.pend_v),
    .in_ready  (buf_ready),
    .in_data   (m_r.pend),
    .out_valid (word_valid),
    .out_ready (word_ready),
    .out_data  (word_data)
  );

  assign word_overrun = m_r.overrun;

  //////////////////////////////////////////////////////////////////////////
  // Checks on the controller

  AST_RESET_LOW: assert property (
    @(posedge tck) disable iff (!trst_n || por_tck)
    (t_r.state == ST_RESET) == !user_tap_reset_n)
    else $error("User reset does not match reset state");

  AST_SHIFT_FLAG: assert property (
    @(posedge tck) disable iff (!trst_n || por_tck)
    data_shift_flag == (t_r.state == ST_SH_DR))
    else $error("Shift flag out of step with Shift-DR");

  AST_CAP_FLAG: assert property (
    @(posedge tck) disable iff (!trst_n || por_tck)
    (t_r.state == ST_SEL_DR && !tms) |=> data_capture_flag ##1
    !data_capture_flag)
    else $error("Capture flag not one state long");

  AST_UPD_FLAG: assert property (
    @(posedge tck) disable iff (!trst_n || por_tck)
    (t_r.state == ST_EX1_DR && tms) |=> data_update_flag)
    else $error("Update flag missing in Update-DR");

  AST_IR_CHANGE: assert property (
    @(posedge tck) disable iff (!trst_n || por_tck)
    ($changed(user_instruction_bus) && t_r.state != ST_RESET)
    |-> t_r.state == ST_UPD_IR)
    else $error("Instruction changed outside Update-IR");

  AST_TMS_RESET: assert property (
    @(posedge tck) disable iff (!trst_n || por_tck)
    tms [*5] |=> t_r.state == ST_RESET)
    else $error("Five TMS highs did not reach reset");

  AST_LEAVE_RESET: assert property (
    @(posedge tck) disable iff (!trst_n || por_tck)
    (t_r.state == ST_RESET && !tms) |=> t_r.state == ST_IDLE)
    else $error("Low TMS in reset did not reach idle");

  AST_SHIFT_STAY: assert property (
    @(posedge tck) disable iff (!trst_n || por_tck)
    (t_r.state == ST_SH_DR && !tms) ##1 (t_r.state == ST_SH_DR && tms)
    |=> t_r.state == ST_EX1_DR)
    else $error("Shift-DR stay or exit wrong");

  AST_IR_PATH: assert property (
    @(posedge tck) disable iff (!trst_n || por_tck)
    (t_r.state == ST_SEL_DR && tms) |=> t_r.state == ST_SEL_IR)
    else $error("Select-DR did not move to Select-IR");

endmodule

/* jtag_host_model.sv */
// Behavioural test port host that clocks the controller one bit at a time
`timescale 1ns/1ps
module jtag_host_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // Clock stands low between frames, pulled-up lines rest high
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock: set tms and tdi while low, take tdo at the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #7.5;
    tck = 1'b1;
    o = tdo;
    #7.5;
    tck = 1'b0;
    tdi = 1'b1; // Released line returns to its pull-up level
  endtask

  // Five clocks with tms high reach reset from any state
  task automatic force_reset();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
  endtask
endmodule

/* user_test_port_tile_tb.sv */
// Self-checking bench of the test port bridge and its word stream
`timescale 1ns/1ps
module user_test_port_tile_tb;
  import tap_bridge_pkg::*;

  logic            mclk, rst, trst_n, user_serial_out, word_ready, o;
  wire logic       tck, tms, tdi, tdo, tdo_oe_n, user_tap_reset_n;
  wire logic       user_serial_in, user_test_clock, word_valid;
  wire logic       data_shift_flag, data_capture_flag, data_update_flag;
  wire logic       word_overrun;
  wire logic [7:0] user_instruction_bus;
  user_word_t      word_data;
  int              fails, n_compared;

  ////////////////////////////////////////////////////////////////////////
  // Clock, host and design
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  jtag_host_model u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  user_test_port_tile u_dut (
    .mclk(mclk), .rst(rst), .tck(tck), .trst_n(trst_n), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .user_instruction_bus(user_instruction_bus),
    .user_tap_reset_n(user_tap_reset_n), .user_serial_in(user_serial_in),
    .user_test_clock(user_test_clock), .user_serial_out(user_serial_out),
    .data_shift_flag(data_shift_flag), .data_capture_flag(data_capture_flag),
    .data_update_flag(data_update_flag), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data),
    .word_overrun(word_overrun)
  );

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared=%0d mismatches=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Full instruction scan from Idle, back to Idle
  task automatic ir_load(input logic [7:0] v);
    logic [7:0] old;
    old = user_instruction_bus;
    for (int i = 0; i < 4; i++) u_host.step(i < 2, 1'b0, o);
    #1;
    check(16'(tdo_oe_n), 16'h0000);
    for (int i = 0; i < 8; i++) u_host.step(i == 7, v[i], o);
    check(16'(user_instruction_bus), 16'(old));
    u_host.step(1'b1, 1'b0, o);
    check(16'(user_instruction_bus), 16'(v));
    u_host.step(1'b0, 1'b0, o);
    check(16'(tdo_oe_n), 16'h0001);
  endtask

  // Data scan from Idle with flag checks; e is the tdo bit expected
  task automatic dr_scan(input logic [7:0] d, input logic e);
    u_host.step(1'b1, 1'b0, o);
    u_host.step(1'b0, 1'b0, o);
    check(16'(data_capture_flag), 16'h0001);
    u_host.step(1'b0, 1'b0, o);
    check(16'({data_capture_flag, data_shift_flag}), 16'h0001);
    for (int i = 0; i < 8; i++) begin
      u_host.step(i == 7, d[i], o);
      check(16'(o), 16'(e));
    end
    check(16'(data_shift_flag), 16'h0000);
    u_host.step(1'b1, 1'b0, o);
    check(16'(data_update_flag), 16'h0001);
    u_host.step(1'b0, 1'b0, o);
    check(16'(data_update_flag), 16'h0000);
  endtask

  // Wait for a word, compare it, then take it with one ready cycle
  task automatic get_word(input user_word_t exp);
    int k;
    k = 0;
    @(negedge mclk);
    while (word_valid !== 1'b1) begin
      k++;
      if (k > 40) begin
        fails++;
        finish_test();
      end
      @(negedge mclk);
    end
    check(word_data, exp);
    @(posedge mclk) word_ready <= 1'b1;
    @(posedge mclk) word_ready <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    check(16'(user_tap_reset_n), 16'h0000);
    check(16'(user_instruction_bus), 16'h00ff);
    check(16'({data_capture_flag, data_shift_flag, data_update_flag}),
          16'h0000);
    $display("test reset done");
  endtask

  task automatic t_leave();
    u_host.tms = 1'b0;
    #40;
    check(16'(user_tap_reset_n), 16'h0000);
    u_host.step(1'b0, 1'b0, o);
    check(16'(user_tap_reset_n), 16'h0001);
    u_host.tdi = 1'b0;
    #1;
    check(16'(user_serial_in), 16'h0000);
    u_host.tck = 1'b1;
    #1;
    check(16'(user_test_clock), 16'h0001);
    u_host.tck = 1'b0;
    u_host.tdi = 1'b1;
    #1;
    check(16'({user_serial_in, user_test_clock}), 16'h0002);
    $display("test leave reset done");
  endtask

  task automatic t_user();
    @(posedge mclk) user_serial_out <= 1'b1;
    ir_load(8'h10);
    dr_scan(8'ha5, 1'b1);
    get_word({8'h10, 8'ha5});
    $display("test user scan done");
  endtask

  task automatic t_bypass();
    logic [7:0] codes [3];
    codes = '{8'h0f, 8'h80, 8'hff};
    foreach (codes[j]) begin
      ir_load(codes[j]);
      dr_scan(8'h00, 1'b0);
      repeat (10) @(negedge mclk);
      check(16'(word_valid), 16'h0000);
    end
    $display("test bypass done");
  endtask

  task automatic t_stream();
    logic [7:0] w [4];
    w = '{8'h3c, 8'hc3, 8'h5a, 8'h96};
    ir_load(8'h7f);
    for (int i = 0; i < 4; i++) begin
      dr_scan(w[i], 1'b1);
      repeat (8) @(negedge mclk);
      check(16'(word_overrun), 16'(i == 3));
    end
    get_word({8'h7f, w[0]});
    get_word({8'h7f, w[1]});
    get_word({8'h7f, w[3]});
    repeat (10) @(negedge mclk);
    check(16'(word_valid), 16'h0000);
    $display("test stream done");
  endtask

  task automatic t_tms_reset();
    for (int i = 0; i < 3; i++) u_host.step(i == 0, 1'b0, o);
    for (int i = 0; i < 5; i++) begin
      u_host.step(1'b1, 1'b0, o);
      if (i == 3) check(16'(user_tap_reset_n), 16'h0001);
    end
    check(16'(user_tap_reset_n), 16'h0000);
    check(16'(user_instruction_bus), 16'h00ff);
    $display("test tms reset done");
  endtask

  task automatic t_trst();
    u_host.step(1'b0, 1'b0, o);
    ir_load(8'h35);
    @(posedge mclk) trst_n <= 1'b0;
    @(negedge mclk);
    check(16'(user_tap_reset_n), 16'h0000);
    check(16'(user_instruction_bus), 16'h00ff);
    @(posedge mclk) trst_n <= 1'b1;
    @(negedge mclk);
    u_host.force_reset();
    check(16'(user_tap_reset_n), 16'h0000);
    u_host.step(1'b0, 1'b0, o);
    check(16'(user_tap_reset_n), 16'h0001);
    $display("test test reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    fails = 0;
    n_compared = 0;
    rst = 1'b1;
    trst_n = 1'b1;
    user_serial_out = 1'b0;
    word_ready = 1'b0;
    @(posedge mclk) trst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    trst_n <= 1'b1;
    repeat (3) u_host.step(1'b1, 1'b1, o);
    @(posedge mclk) rst <= 1'b0;
    @(negedge mclk);
    repeat (2) u_host.step(1'b1, 1'b1, o);
    t_reset();
    t_leave();
    t_user();
    t_bypass();
    t_stream();
    t_tms_reset();
    t_trst();
    finish_test();
  end
endmodule
